// ===== rtl/lpdc_defines.svh
// constants for the led pump dimming control block
// Operation
// - host holds input high 10 us before dimming
// - host low pulse lasts 0.2 to 100 us
// - host high gap at least 0.2 us
// - low for 1.5 ms enters shutdown
// - new current settles within 40 us
// - undervoltage disables channels, enters shutdown
// - first rise from shutdown gives full scale
// - sinks high impedance in shutdown
// - current set pin released in shutdown
// - pump starts in 1x ratio
// - adequate headroom keeps 1x ratio
// - low headroom steps 1x to 1.33x after 400 us
// - same delayed steps to 1.5x, 2x
// - sufficient supply returns directly to 1x
// - each rising edge halves current level
// - edge after lowest level restores full scale
// - low pulses below minimum are filtered
`ifndef LPDC_DEFINES_SVH
`define LPDC_DEFINES_SVH
`define LPDC_CLK_MHZ 250
`define LPDC_SETUP_NS 10000
`define LPDC_LO_MIN_NS 200
`define LPDC_LO_MAX_NS 100000
`define LPDC_HI_MIN_NS 200
`define LPDC_OFF_NS 1500000
`define LPDC_SETTLE_NS 40000
`define LPDC_STEP_NS 400000
`define LPDC_CYC(ns) (((ns) * `LPDC_CLK_MHZ + 999) / 1000)
`define LPDC_CYC_DN(ns) (((ns) * `LPDC_CLK_MHZ) / 1000)
`define LPDC_LVL_FULL 3'h0
`define LPDC_LVL_LAST 3'h5
`define LPDC_CNT_W 20
`endif

// ===== rtl/lpdc_pkg.sv
// types shared by both ends of the dimming link
package lpdc_pkg;
  typedef enum logic [3:0] {
    LPDC_R1X = 4'h1,
    LPDC_R133 = 4'h2,
    LPDC_R15 = 4'h4,
    LPDC_R2X = 4'h8
  } lpdc_ratio_type;
  typedef enum logic [2:0] {
    LPDC_OFF = 3'h1,
    LPDC_HIGH = 3'h2,
    LPDC_LOW = 3'h4
  } lpdc_dev_type;
  typedef enum logic [3:0] {
    LPDC_H_IDLE = 4'h1,
    LPDC_H_SETUP = 4'h2,
    LPDC_H_LO = 4'h4,
    LPDC_H_HI = 4'h8
  } lpdc_host_type;
endpackage

// ===== rtl/lpdc_link_if.sv
// one-wire enable and dimming link between host and driver
`timescale 1ns/1ps
interface lpdc_link_if;
  logic enable_dim_input;
  modport host (output enable_dim_input);
  modport device (input enable_dim_input);
endinterface

// ===== rtl/lpdc_device.sv
// driver end: one-wire decode, dimming level and pump ratio control
`timescale 1ns/1ps
`include "lpdc_defines.svh"
module lpdc_device #(
  parameter int OFF_CYC = `LPDC_CYC(`LPDC_OFF_NS),
  parameter int STEP_CYC = `LPDC_CYC_DN(`LPDC_STEP_NS),
  parameter int SETTLE_CYC = `LPDC_CYC_DN(`LPDC_SETTLE_NS)
) (
  input wire logic mclk,
  input wire logic rst_n,
  lpdc_link_if.device link,
  input wire logic undervoltage_lockout,
  input wire logic [3:0] headroom_low,
  input wire logic supply_ok_1x,
  output logic enabled,
  output logic [2:0] dim_level,
  output logic [3:0] sink_oe,
  output logic current_set_oe,
  output logic settling,
  output lpdc_pkg::lpdc_ratio_type pump_ratio
);
  localparam int LO_MIN = `LPDC_CYC(`LPDC_LO_MIN_NS);
  logic en_s1_r, en_s2_r, uv_s1_r, uv_s2_r;
  lpdc_pkg::lpdc_dev_type st_r, st_nxt;
  lpdc_pkg::lpdc_ratio_type rat_r, rat_nxt;
  logic [`LPDC_CNT_W-1:0] lo_r, lo_nxt, df_r, df_nxt, st_cnt_r, st_cnt_nxt;
  logic [2:0] lvl_r, lvl_nxt;
  logic dim_ev;

  // two-stage synchronisers for pin and undervoltage
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      en_s1_r <= 1'b0;
      en_s2_r <= 1'b0;
      uv_s1_r <= 1'b0;
      uv_s2_r <= 1'b0;
    end else begin
      en_s1_r <= link.enable_dim_input;
      en_s2_r <= en_s1_r;
      uv_s1_r <= undervoltage_lockout;
      uv_s2_r <= uv_s1_r;
    end
  end

  // line state, low timer, dimming level
  always_comb begin
    st_nxt = st_r;
    lo_nxt = lo_r;
    lvl_nxt = lvl_r;
    dim_ev = 1'b0;
    unique case (st_r)
      lpdc_pkg::LPDC_OFF: begin
        lvl_nxt = `LPDC_LVL_FULL;
        if (en_s2_r) begin
          st_nxt = lpdc_pkg::LPDC_HIGH;
          dim_ev = 1'b1;
        end
      end
      lpdc_pkg::LPDC_HIGH: begin
        lo_nxt = '0;
        if (!en_s2_r) st_nxt = lpdc_pkg::LPDC_LOW;
      end
      lpdc_pkg::LPDC_LOW: begin
        lo_nxt = lo_r + 1'b1;
        if (int'(lo_r) + 2 >= OFF_CYC) begin
          st_nxt = lpdc_pkg::LPDC_OFF;
        end else if (en_s2_r) begin
          st_nxt = lpdc_pkg::LPDC_HIGH;
          if (int'(lo_r) + 1 >= LO_MIN) begin
            dim_ev = 1'b1;
            lvl_nxt = (lvl_r == `LPDC_LVL_LAST) ? `LPDC_LVL_FULL
                      : lvl_r + 3'h1;
          end
        end
      end
    endcase
    if (uv_s2_r) begin
      st_nxt = lpdc_pkg::LPDC_OFF;
      lvl_nxt = `LPDC_LVL_FULL;
      dim_ev = 1'b0;
    end
  end

  // settle window after enable or a dimming step (not on entry to shutdown)
  always_comb begin
    st_cnt_nxt = st_cnt_r;
    if (dim_ev) st_cnt_nxt = `LPDC_CNT_W'(SETTLE_CYC);
    else if (st_cnt_r != '0) st_cnt_nxt = st_cnt_r - 1'b1;
  end

  // pump ratio sequencing with filter delay
  always_comb begin
    rat_nxt = rat_r;
    df_nxt = '0;
    if (st_nxt == lpdc_pkg::LPDC_OFF) begin
      rat_nxt = lpdc_pkg::LPDC_R1X;
    end else if (rat_r != lpdc_pkg::LPDC_R1X && supply_ok_1x) begin
      rat_nxt = lpdc_pkg::LPDC_R1X;
    end else if (headroom_low != 4'h0 && rat_r != lpdc_pkg::LPDC_R2X) begin
      df_nxt = df_r + 1'b1;
      if (int'(df_r) + 1 >= STEP_CYC) begin
        df_nxt = '0;
        unique case (rat_r)
          lpdc_pkg::LPDC_R1X: rat_nxt = lpdc_pkg::LPDC_R133;
          lpdc_pkg::LPDC_R133: rat_nxt = lpdc_pkg::LPDC_R15;
          default: rat_nxt = lpdc_pkg::LPDC_R2X;
        endcase
      end
    end // otherwise hold ratio
  end

  // state registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= lpdc_pkg::LPDC_OFF;
      lo_r <= '0;
      lvl_r <= `LPDC_LVL_FULL;
      rat_r <= lpdc_pkg::LPDC_R1X;
      df_r <= '0;
      st_cnt_r <= '0;
    end else begin
      st_r <= st_nxt;
      lo_r <= lo_nxt;
      lvl_r <= lvl_nxt;
      rat_r <= rat_nxt;
      df_r <= df_nxt;
      st_cnt_r <= st_cnt_nxt;
    end
  end

  // registered outputs
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      enabled <= 1'b0;
      dim_level <= `LPDC_LVL_FULL;
      sink_oe <= 4'h0;
      current_set_oe <= 1'b0;
      settling <= 1'b0;
      pump_ratio <= lpdc_pkg::LPDC_R1X;
    end else begin
      enabled <= st_nxt != lpdc_pkg::LPDC_OFF;
      dim_level <= lvl_nxt;
      sink_oe <= {4{st_nxt != lpdc_pkg::LPDC_OFF}};
      current_set_oe <= st_nxt != lpdc_pkg::LPDC_OFF;
      settling <= st_cnt_nxt != '0;
      pump_ratio <= rat_nxt;
    end
  end
endmodule

// ===== rtl/lpdc_host.sv
// host end: drives enable, dimming pulses and shutdown on the wire
`timescale 1ns/1ps
`include "lpdc_defines.svh"
module lpdc_host #(
  parameter int OFF_CYC = `LPDC_CYC(`LPDC_OFF_NS),
  parameter int SETUP_CYC = `LPDC_CYC(`LPDC_SETUP_NS),
  parameter int LO_CYC = `LPDC_CYC(`LPDC_LO_MIN_NS),
  parameter int HI_CYC = `LPDC_CYC(`LPDC_HI_MIN_NS)
) (
  input wire logic mclk,
  input wire logic rst_n,
  lpdc_link_if.host link,
  input wire logic cmd_enable,
  input wire logic cmd_dim,
  input wire logic cmd_off,
  output logic busy,
  output logic line_level
);
  lpdc_pkg::lpdc_host_type st_r, st_nxt;
  logic [`LPDC_CNT_W-1:0] cnt_r, cnt_nxt;
  logic off_r, off_nxt, pin_r, pin_nxt;

  // wire sequencer; off_r marks a low that ends in shutdown
  always_comb begin
    st_nxt = st_r;
    cnt_nxt = cnt_r + 1'b1;
    off_nxt = off_r;
    unique case (st_r)
      lpdc_pkg::LPDC_H_IDLE: begin
        cnt_nxt = '0;
        if (cmd_off && pin_r) begin
          st_nxt = lpdc_pkg::LPDC_H_LO;
          off_nxt = 1'b1;
        end else if (cmd_enable && !pin_r) begin
          st_nxt = lpdc_pkg::LPDC_H_SETUP;
        end else if (cmd_dim && pin_r) begin
          st_nxt = lpdc_pkg::LPDC_H_LO;
          off_nxt = 1'b0;
        end
      end
      lpdc_pkg::LPDC_H_SETUP:
        if (int'(cnt_r) + 1 >= SETUP_CYC) st_nxt = lpdc_pkg::LPDC_H_IDLE;
      lpdc_pkg::LPDC_H_LO: begin
        if (int'(cnt_r) + 1 >= (off_r ? OFF_CYC : LO_CYC)) begin
          cnt_nxt = '0;
          st_nxt = off_r ? lpdc_pkg::LPDC_H_IDLE : lpdc_pkg::LPDC_H_HI;
        end
      end
      lpdc_pkg::LPDC_H_HI:
        if (int'(cnt_r) + 1 >= HI_CYC) st_nxt = lpdc_pkg::LPDC_H_IDLE;
    endcase
    pin_nxt = (st_nxt == lpdc_pkg::LPDC_H_LO) ? 1'b0
              : (st_nxt == lpdc_pkg::LPDC_H_IDLE && off_nxt) ? 1'b0
              : (st_nxt == lpdc_pkg::LPDC_H_IDLE) ? pin_r : 1'b1;
    if (st_nxt == lpdc_pkg::LPDC_H_SETUP) off_nxt = 1'b0;
  end

  // sequencer registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= lpdc_pkg::LPDC_H_IDLE;
      cnt_r <= '0;
      off_r <= 1'b1;
      pin_r <= 1'b0;
      busy <= 1'b0;
    end else begin
      st_r <= st_nxt;
      cnt_r <= cnt_nxt;
      off_r <= off_nxt;
      pin_r <= pin_nxt;
      busy <= st_nxt != lpdc_pkg::LPDC_H_IDLE;
    end
  end

  assign link.enable_dim_input = pin_r;
  assign line_level = pin_r;
endmodule

// ===== dv/lpdc_assertions.sv
// concurrent checks on the dimming wire and driver outputs
`timescale 1ns/1ps
module lpdc_checker #(
  parameter int OFF_CYC = 200,
  parameter int STEP_CYC = 20,
  parameter int LO_MIN = 50,
  parameter int LO_MAX = 25000,
  parameter int HI_MIN = 50,
  parameter int SETUP_MIN = 20
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic enable_dim_input,
  input wire logic undervoltage_lockout,
  input wire logic [3:0] headroom_low,
  input wire logic supply_ok_1x,
  input wire logic enabled,
  input wire logic [2:0] dim_level,
  input wire logic [3:0] sink_oe,
  input wire logic current_set_oe,
  input wire logic settling,
  input wire lpdc_pkg::lpdc_ratio_type pump_ratio
);
  int lcnt_r, lcnt_nxt, hcnt_r, hcnt_nxt, hrun_r, hrun_nxt;
  logic fresh_r, fresh_nxt;
  // run lengths of low wire, high wire and lost headroom
  always_comb begin
    lcnt_nxt = enable_dim_input ? 0 : lcnt_r + 1;
    hrun_nxt = enable_dim_input ? hrun_r + 1 : 0;
    hcnt_nxt = (headroom_low != 4'h0) ? hcnt_r + 1 : 0;
    fresh_nxt = !enabled || (fresh_r && enable_dim_input); // first high
  end
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      lcnt_r <= 0;
      hcnt_r <= 0;
      hrun_r <= 0;
      fresh_r <= 1'b1;
    end else begin
      lcnt_r <= lcnt_nxt;
      hcnt_r <= hcnt_nxt;
      hrun_r <= hrun_nxt;
      fresh_r <= fresh_nxt;
    end
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  property p_rise_en; $rose(enable_dim_input) && !enabled &&
    !undervoltage_lockout |-> ##3 enabled && sink_oe == 4'hf; endproperty
  a_rise_en: assert property (p_rise_en)
    else $error("no enable after rise");
  property p_off_hiz; !enabled |-> sink_oe == 4'h0 && !current_set_oe;
  endproperty
  a_off_hiz: assert property (p_off_hiz)
    else $error("pins driven while off");
  property p_undervoltage_lockout; undervoltage_lockout |-> ##[1:4] !enabled; endproperty
  a_undervoltage_lockout: assert property (p_undervoltage_lockout) else $error("undervoltage ignored");
  property p_off_clr; $fell(enabled) |-> ##[0:1] dim_level == 3'h0 &&
    pump_ratio == lpdc_pkg::LPDC_R1X; endproperty
  a_off_clr: assert property (p_off_clr)
    else $error("state kept over shutdown");
  property p_stay_1x; pump_ratio == lpdc_pkg::LPDC_R1X &&
    headroom_low == 4'h0 |=> pump_ratio == lpdc_pkg::LPDC_R1X; endproperty
  a_stay_1x: assert property (p_stay_1x) else $error("left 1x");
  property p_step; pump_ratio != $past(pump_ratio) &&
    pump_ratio != lpdc_pkg::LPDC_R1X |-> hcnt_r >= STEP_CYC - 1 &&
    pump_ratio == $past(pump_ratio) << 1; endproperty
  a_step: assert property (p_step) else $error("bad step");
  property p_drop_1x; supply_ok_1x && pump_ratio != lpdc_pkg::LPDC_R1X
    |=> pump_ratio == lpdc_pkg::LPDC_R1X; endproperty
  a_drop_1x: assert property (p_drop_1x) else $error("no return");
  property p_dim; enabled && $past(enabled) &&
    dim_level != $past(dim_level) |-> dim_level ==
    ($past(dim_level) == 3'h5 ? 3'h0 : $past(dim_level) + 3'h1); endproperty
  a_dim: assert property (p_dim) else $error("bad level step");
  property p_off_time; lcnt_r > OFF_CYC + 5 |-> !enabled; endproperty
  a_off_time: assert property (p_off_time) else $error("no shutdown");
  property p_settle; $rose(settling) |=> settling [*8]; endproperty
  a_settle: assert property (p_settle) else $error("short settle");
  property p_lo_len; $rose(enable_dim_input) && enabled |->
    lcnt_r >= LO_MIN && lcnt_r <= LO_MAX; endproperty
  a_lo_len: assert property (p_lo_len)
    else $error("dimming low out of range");
  property p_hi_len; $fell(enable_dim_input) && enabled |->
    hrun_r >= (fresh_r ? SETUP_MIN : HI_MIN); endproperty
  a_hi_len: assert property (p_hi_len)
    else $error("high phase too short");
endmodule

// ===== dv/led_pump_dimming_control_tb_top.sv
// testbench: host and driver ends joined on one wire
`timescale 1ns/1ps
module led_pump_dimming_control_tb_top;
  logic mclk, rst_n, undervoltage_lockout, supply_ok_1x, enabled;
  logic cmd_enable, cmd_dim, cmd_off, busy, current_set_oe, settling;
  logic line_level;
  logic [3:0] headroom_low, sink_oe;
  logic [2:0] dim_level;
  lpdc_pkg::lpdc_ratio_type pump_ratio;
  int err_count = 0, n_compared = 0, cyc = 0;
  lpdc_link_if link();
  lpdc_host #(.OFF_CYC(200), .SETUP_CYC(20)) i_lpdc_host (.mclk, .rst_n,
    .link, .cmd_enable, .cmd_dim, .cmd_off, .busy, .line_level);
  lpdc_device #(.OFF_CYC(200), .STEP_CYC(20), .SETTLE_CYC(10))
    i_lpdc_device (.mclk, .rst_n, .link, .undervoltage_lockout,
    .headroom_low, .supply_ok_1x, .enabled, .dim_level, .sink_oe,
    .current_set_oe, .settling, .pump_ratio);
  lpdc_checker i_lpdc_checker (.mclk,
    .rst_n, .enable_dim_input(link.enable_dim_input), .undervoltage_lockout,
    .headroom_low, .supply_ok_1x, .enabled, .dim_level, .sink_oe,
    .current_set_oe, .settling, .pump_ratio);
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic check(input string nm, input logic [3:0] exp, got);
    n_compared++;
    if (got !== exp) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // one host command, then wait for its sequence to finish
  task automatic cmd(ref logic c);
    c = 1'b1;
    tick(1);
    c = 1'b0;
    for (int k = 0; k < 600 && busy !== 1'b0; k++) tick(1);
    check("busy", 4'h0, busy);
    tick(5);
  endtask
  task automatic end_sim();
    $display("compared %0d errors %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    mclk = 1'b0;
    forever #2 mclk = ~mclk;
  end
  // hang guard
  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      end_sim();
    end
  end
  initial begin
    {rst_n, undervoltage_lockout, supply_ok_1x} = 3'h0;
    {cmd_enable, cmd_dim, cmd_off, headroom_low} = 7'h00;
    tick(2);
    rst_n = 1'b1;
    check("sink_oe", 4'h0, sink_oe);
    check("set_oe", 4'h0, current_set_oe);
    check("ratio", 4'h1, pump_ratio);
    cmd(cmd_enable);
    check("enabled", 4'h1, enabled);
    check("sink_oe", 4'hf, sink_oe);
    check("line", 4'h1, line_level);
    check("settling", 4'h0, settling);
    // six rising edges walk the whole level cycle
    for (int i = 1; i <= 6; i++) begin
      cmd(cmd_dim);
      check("level", 4'(i % 6), dim_level);
    end
    tick(30);
    check("ratio", 4'h1, pump_ratio);
    headroom_low = 4'h2;
    tick(24);
    check("ratio", 4'h2, pump_ratio);
    headroom_low = 4'h0;
    tick(1);
    headroom_low = 4'h2;
    tick(10);
    headroom_low = 4'h0;
    tick(1);
    headroom_low = 4'h2;
    tick(15);
    check("ratio", 4'h2, pump_ratio);
    tick(10);
    check("ratio", 4'h4, pump_ratio);
    tick(40);
    check("ratio", 4'h8, pump_ratio);
    headroom_low = 4'h0;
    supply_ok_1x = 1'b1;
    tick(2);
    check("ratio", 4'h1, pump_ratio);
    supply_ok_1x = 1'b0;
    cmd(cmd_dim);
    headroom_low = 4'h1;
    tick(24);
    headroom_low = 4'h0;
    cmd(cmd_off);
    check("enabled", 4'h0, enabled);
    check("line", 4'h0, line_level);
    check("level", 4'h0, dim_level);
    check("ratio", 4'h1, pump_ratio);
    cmd(cmd_enable);
    check("level", 4'h0, dim_level);
    undervoltage_lockout = 1'b1;
    tick(5);
    check("enabled", 4'h0, enabled);
    check("sink_oe", 4'h0, sink_oe);
    end_sim();
  end
endmodule
